// file: dv/host_model.sv
`timescale 1ns/100ps
`include "pattern_order_defines.svh"
// Bus master standing in for the control software
module host_model (
  input wire logic clock,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic last_err; // Error answer of the last transfer
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
  end
  // One transfer, entered just after a rising edge
  task automatic rd(input logic [7:0] a, output logic [31:0] r,
    input logic w = 1'b0, input logic [31:0] d = 32'h0);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // Released lines lose the old value
    pwdata <= ~d;
    @(posedge clock);
  endtask
  // Write, answer data unused
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    rd(a, r, 1'b1, d);
  endtask
  // New display order, one slot index per nibble
  task automatic load(input logic [31:0] rows, input int len);
    wr(`REG_COMMAND, 32'h4);
    for (int i = 0; i < len; i++)
    begin
      wr(`REG_ORDER_SELECT, 32'(i));
      wr(`REG_ORDER_ENTRY, {28'h0, rows[4*i +: 4]});
    end
    wr(`REG_ORDER_LENGTH, 32'(len));
  endtask
endmodule

// file: dv/pattern_order_chk.sv
`timescale 1ns/100ps
// Watches bus timing and display behaviour at the sequencer ports
module pattern_order_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trigger_in,
  input wire pattern_order_pkg::display_out_type display
);
  // One clock domain for every check
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Answer only in the second access cycle
  property p_ready_late;
    pready |-> psel && penable && $past(psel && penable);
  endproperty
  a_ready_late: assert property (p_ready_late)
    else $error("pready came outside the second access cycle");
  // Exactly one wait state
  property p_ready_due;
    psel && $rose(penable) |=> pready;
  endproperty
  a_ready_due: assert property (p_ready_due)
    else $error("pready missing in second access cycle");
  // Answer is a single-cycle pulse
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready stood longer than one cycle");
  // Read data idles at zero
  property p_rdata_idle;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("prdata or pslverr active without pready");
  // Error answer exactly for unmapped offsets
  property p_unmapped;
    pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h10,
      8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c});
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("pslverr does not match the address map");
  // Display frozen while the trigger wait lasts
  property p_hold_wait;
    display.waiting ##1 display.waiting |-> $stable(display.pattern_word)
      && $stable(display.bit_plane) && $stable(display.blank);
  endproperty
  a_hold_wait: assert property (p_hold_wait)
    else $error("display changed during trigger wait");
  // Trigger ends the wait promptly
  property p_trig_go;
    display.waiting && trigger_in |-> ##[1:3] !display.waiting;
  endproperty
  a_trig_go: assert property (p_trig_go)
    else $error("trigger did not end the wait");
  // Stop command blanks the display
  property p_stop_blank;
    psel && penable && pready && pwrite && paddr == 8'h04 && pwdata[2]
      |-> ##[1:3] display.blank && !display.waiting;
  endproperty
  a_stop_blank: assert property (p_stop_blank)
    else $error("display not blank after stop");
endmodule

// file: dv/tb.sv
`timescale 1ns/100ps
`include "pattern_order_defines.svh"
// Self-checking bench for the reorder sequencer
module tb;
  logic clock;
  logic rstn;
  logic trigger_in;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pattern_order_pkg::display_out_type disp;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0; // Hang guard count
  int n; // Measured segment length
  logic [31:0] r; // Read data
  logic [31:0] img [4]; // Image word per slot
  logic [2:0] col [4]; // Colour per slot
  host_model host (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  pattern_order_lut_sequencer #(.SLOT_W(3), .SLOTS(8)) dut (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in),
    .display(disp));
  // Free-running clock
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Cut a hang short
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 98000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // Counted comparison
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Length within two cycles of a time in microseconds
  function automatic logic near(int n, int us);
    return n >= us * 125 - 2 && n <= us * 125 + 2;
  endfunction
  // Visible state: word, blank, waiting
  function automatic logic [33:0] look();
    return disp.blank ? {32'h0, 1'b1, disp.waiting}
      : {disp.pattern_word, 1'b0, disp.waiting};
  endfunction
  // Wait until a state shows, bounded
  task automatic sync(input logic [33:0] v);
    for (int k = 0; k < 20000 && look() !== v; k++)
      @(posedge clock);
    chk(look(), v);
  endtask
  // Cycles until the visible state changes
  task automatic seg(output int n);
    logic [33:0] v;
    v = look();
    n = 0;
    while (look() === v && n < 20000)
    begin
      @(posedge clock);
      n++;
    end
  endtask
  // Upload one slot: 105 us, no dark, one plane
  task automatic slot(input int s, input logic trig);
    host.wr(`REG_SLOT_SELECT, 32'(s));
    host.wr(`REG_EXPOSURE, 32'h69);
    host.wr(`REG_DARK, 32'h0);
    host.wr(`REG_ATTRIBUTE, {23'h0, trig, 1'b0, col[s], 4'h1});
    host.wr(`REG_IMAGE, img[s]);
  endtask
  // Pulse the trigger input
  task automatic fire();
    trigger_in <= 1'b1;
    @(posedge clock);
    trigger_in <= 1'b0;
  endtask
  // Report and stop
  task automatic end_sim();
    $display("Compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    trigger_in = 1'b0;
    void'($urandom(44));
    for (int i = 0; i < 4; i++)
    begin
      img[i] = $urandom() | 32'h1;
      col[i] = 3'($urandom());
    end
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    host.wr(`REG_CONTROL, 32'h4);
    host.wr(`REG_ORDER_ENTRY, 32'h0);
    host.rd(`REG_STATUS, r);
    chk(r[5], 1'b1);
    host.wr(`REG_STATUS, 32'h30);
    host.rd(8'h0c, r);
    chk({r, host.last_err}, {32'h0, 1'b1});
    host.wr(`REG_CONTROL, 32'ha);
    for (int s = 0; s < 4; s++)
      slot(s, s == 1);
    host.wr(`REG_SLOT_SELECT, 32'h0);
    host.wr(`REG_EXPOSURE, 32'h68);
    host.rd(`REG_STATUS, r);
    chk(r[5:4], 2'b01);
    host.wr(`REG_STATUS, 32'h30);
    host.wr(`REG_CONTROL, 32'h3);
    host.load(32'h102, 3);
    host.wr(`REG_COMMAND, 32'h1);
    sync({img[2], 2'b00});
    chk(disp.color, col[2]);
    seg(n);
    chk(near(n, 105), 1'b1);
    chk(look(), {img[0], 2'b00});
    seg(n);
    chk(near(n, 105), 1'b1);
    chk(look(), {32'h0, 2'b10});
    seg(n);
    chk(near(n, 105), 1'b1);
    chk(look(), {32'h0, 2'b11});
    repeat ($urandom_range(40, 5)) @(posedge clock);
    chk(look(), {32'h0, 2'b11});
    fire();
    sync({img[1], 2'b00});
    chk(disp.color, col[1]);
    sync({img[2], 2'b00});
    host.wr(`REG_COMMAND, 32'h4);
    host.rd(`REG_STATUS, r);
    chk({r[24:16], r[2:0]}, 12'h0);
    host.wr(`REG_CONTROL, 32'h3);
    host.load(32'h12, 2);
    host.wr(`REG_COMMAND, 32'h1);
    sync({img[2], 2'b00});
    host.wr(`REG_COMMAND, 32'h2);
    host.rd(`REG_STATUS, r);
    chk({r[6], r[2:0]}, 4'hb);
    host.wr(`REG_COMMAND, 32'h1);
    seg(n);
    chk(look(), {img[2], 2'b01});
    fire();
    sync({img[1], 2'b00});
    seg(n);
    chk(near(n, 105), 1'b1);
    end_sim();
  end
endmodule
bind pattern_order_lut_sequencer pattern_order_chk chk (.clock(clock),
  .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .trigger_in(trigger_in), .display(display));

// file: verilog/pattern_order_defines.svh
`ifndef PATTERN_ORDER_DEFINES_SVH
`define PATTERN_ORDER_DEFINES_SVH

// Register byte offsets
`define REG_CONTROL 8'h00
`define REG_COMMAND 8'h04
`define REG_STATUS 8'h08
`define REG_SLOT_SELECT 8'h10
`define REG_EXPOSURE 8'h14
`define REG_DARK 8'h18
`define REG_ATTRIBUTE 8'h1c
`define REG_IMAGE 8'h20
`define REG_ORDER_SELECT 8'h24
`define REG_ORDER_ENTRY 8'h28
`define REG_ORDER_LENGTH 8'h2c

// Control fields
`define CTL_REPEAT 0
`define CTL_MODE_LO 1
`define CTL_MODE_HI 2
`define CTL_UPLOAD 3

// Command fields
`define CMD_START 0
`define CMD_PAUSE 1
`define CMD_STOP 2

// Status fields
`define STS_STATE_LO 0
`define STS_STATE_HI 2
`define STS_WAITING 3
`define STS_ERR_SHORT 4
`define STS_ERR_REFUSED 5
`define STS_PAUSED 6
`define STS_POS_LO 16

// Attribute fields
`define ATT_DEPTH_LO 0
`define ATT_DEPTH_HI 3
`define ATT_COLOR_LO 4
`define ATT_COLOR_HI 6
`define ATT_TRIGGER 8

// Timing
`define CLK_PERIOD_PS 8000
`define PS_PER_US 1000000
`define US_TICK_CYCLES (`PS_PER_US / `CLK_PERIOD_PS)
`define BLACK_TIME_US 105
`define MIN_PATTERN_US 105

// Reset values
`define CONTROL_RESET 32'h0000_0000

`endif

// file: verilog/pattern_order_lut_sequencer.sv
`timescale 1ns/100ps
`include "pattern_order_defines.svh"

// Notes on behaviour
// [R1] Reorder table rows name slots, shown ascending
// [R2] Reorder writes never touch image memory
// [R3] Shown pattern keeps its own slot attributes
// [R4] One slot may fill many table rows
// [R5] Triggered pattern waits; predecessor ends with black
// [R6] Black tail belongs to preceding slot, travels
// [R7] Black tail lasts 105 us
// [R8] Exposure under 105 us is refused
// [R9] No black tail: last plane held while waiting
// [R10] Flash mode: images fixed, attributes follow table
// [R11] Reordering unavailable in video mode
// [R12] Host stops sequence before applying table
// [R13] Repeat restarts from first row after last
// [R14] Host writes only slots already uploaded
// [R15] Stop restarts from first row; pause resumes
module pattern_order_lut_sequencer #(
  parameter int SLOT_W = 9,
  parameter int SLOTS = 512
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_in,
  output pattern_order_pkg::display_out_type display
);

  // Tick width for one microsecond
  localparam logic [6:0] TICK_LAST = 7'(`US_TICK_CYCLES - 1);
  localparam logic [23:0] BLACK_US = 24'(`BLACK_TIME_US);
  localparam logic [23:0] MIN_US = 24'(`MIN_PATTERN_US);

  // Pattern storage, per slot
  pattern_order_pkg::slot_attr_type attr_q [SLOTS];
  logic [31:0] image_q [SLOTS];
  // Reorder table rows
  logic [SLOT_W-1:0] order_q [SLOTS];

  // Software registers
  logic repeat_q;
  pattern_order_pkg::source_mode_type mode_q;
  logic upload_q;
  logic [SLOT_W-1:0] slot_sel_q;
  logic [SLOT_W-1:0] order_sel_q;
  logic [SLOT_W:0] order_len_q;
  logic err_short_q;
  logic err_refused_q;

  // APB answer flops
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Sequencer state
  pattern_order_pkg::seq_state_type state_q;
  logic paused_q;
  logic [SLOT_W-1:0] pos_q;
  logic [SLOT_W-1:0] slot_q;
  logic [6:0] tick_q;
  logic [23:0] us_q;
  logic [23:0] acc_q;
  pattern_order_pkg::display_out_type display_q;

  // Bus decode and sequencer helpers
  logic access;
  logic wr;
  logic rd_known;
  logic idle;
  logic us_tick;
  logic [SLOT_W-1:0] fetch_slot;
  logic [SLOT_W-1:0] next_slot;
  logic tail_black;
  logic last_row;
  logic cmd_start;
  logic cmd_pause;
  logic cmd_stop;
  logic attr_write_ok;
  logic order_write_ok;
  logic [31:0] rd_value;
  pattern_order_pkg::slot_attr_type cur_attr;
  pattern_order_pkg::slot_attr_type fetch_attr;
  pattern_order_pkg::slot_attr_type sel_attr;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign display = display_q;

  // Access phase completes on the registered ready
  assign access = psel && penable && pready_q;
  assign wr = access && pwrite;
  assign idle = (state_q == pattern_order_pkg::st_idle);
  assign cmd_start = wr && (paddr == `REG_COMMAND) && pwdata[`CMD_START];
  assign cmd_pause = wr && (paddr == `REG_COMMAND) && pwdata[`CMD_PAUSE];
  assign cmd_stop = wr && (paddr == `REG_COMMAND) && pwdata[`CMD_STOP];
  assign us_tick = (tick_q == TICK_LAST);
  assign sel_attr = attr_q[slot_sel_q];
  assign cur_attr = attr_q[slot_q];
  // Video mode ignores the table: rows play in stored order
  assign fetch_slot = (mode_q == pattern_order_pkg::mode_video) ?
                      pos_q : order_q[pos_q]; // [R11] [R1]
  assign fetch_attr = attr_q[fetch_slot]; // [R3] [R4]
  // Black tail follows the slot whose stored successor is triggered
  assign next_slot = (32'(slot_q) + 32'd1 >= 32'(SLOTS)) ?
                     '0 : SLOT_W'(32'(slot_q) + 32'd1);
  assign tail_black = attr_q[next_slot].trigger; // [R5] [R6]
  assign last_row = ({1'b0, pos_q} + 1'b1 >= order_len_q);
  // Pattern data only changes during a stopped upload window
  assign attr_write_ok = upload_q && idle; // [R2]
  // Table edits need a stopped sequence outside video mode
  assign order_write_ok = idle && (mode_q != pattern_order_pkg::mode_video);

  // Read mux and address check
  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_known = 1'b1;
    case (paddr)
      `REG_CONTROL:
      begin
        rd_value[`CTL_REPEAT] = repeat_q;
        rd_value[`CTL_MODE_HI:`CTL_MODE_LO] = mode_q;
        rd_value[`CTL_UPLOAD] = upload_q;
      end
      `REG_COMMAND: rd_value = 32'h0000_0000;
      `REG_STATUS:
      begin
        rd_value[`STS_STATE_HI:`STS_STATE_LO] = state_q;
        rd_value[`STS_WAITING] = display_q.waiting;
        rd_value[`STS_ERR_SHORT] = err_short_q;
        rd_value[`STS_ERR_REFUSED] = err_refused_q;
        rd_value[`STS_PAUSED] = paused_q;
        rd_value[`STS_POS_LO +: SLOT_W] = pos_q;
      end
      `REG_SLOT_SELECT: rd_value[SLOT_W-1:0] = slot_sel_q;
      `REG_EXPOSURE: rd_value[23:0] = sel_attr.exposure_us;
      `REG_DARK: rd_value[23:0] = sel_attr.dark_us;
      `REG_ATTRIBUTE:
      begin
        rd_value[`ATT_DEPTH_HI:`ATT_DEPTH_LO] = sel_attr.depth;
        rd_value[`ATT_COLOR_HI:`ATT_COLOR_LO] = sel_attr.color;
        rd_value[`ATT_TRIGGER] = sel_attr.trigger;
      end
      `REG_IMAGE: rd_value = image_q[slot_sel_q];
      `REG_ORDER_SELECT: rd_value[SLOT_W-1:0] = order_sel_q;
      `REG_ORDER_ENTRY: rd_value[SLOT_W-1:0] = order_q[order_sel_q];
      `REG_ORDER_LENGTH: rd_value[SLOT_W:0] = order_len_q;
      default: rd_known = 1'b0;
    endcase
  end

  // APB handshake: ready one cycle into the access phase
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (psel && penable && !pready_q)
    begin
      pready_q <= 1'b1;
      pslverr_q <= !rd_known;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_value;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  // Control and selector registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      repeat_q <= 1'(`CONTROL_RESET >> `CTL_REPEAT);
      mode_q <= pattern_order_pkg::mode_flash;
      upload_q <= 1'b0;
      slot_sel_q <= '0;
      order_sel_q <= '0;
      order_len_q <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        `REG_CONTROL:
        begin
          repeat_q <= pwdata[`CTL_REPEAT]; // [R13]
          mode_q <= pattern_order_pkg::source_mode_type'(
                    pwdata[`CTL_MODE_HI:`CTL_MODE_LO]);
          upload_q <= pwdata[`CTL_UPLOAD];
        end
        `REG_SLOT_SELECT: slot_sel_q <= pwdata[SLOT_W-1:0];
        `REG_ORDER_SELECT: order_sel_q <= pwdata[SLOT_W-1:0];
        `REG_ORDER_LENGTH:
          if (order_write_ok)
            order_len_q <= pwdata[SLOT_W:0]; // [R12]
        default: ;
      endcase
    end
  end

  // Error flags: hardware set wins over write-one clear
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      err_short_q <= 1'b0;
      err_refused_q <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `REG_EXPOSURE && pwdata[23:0] < MIN_US)
        err_short_q <= 1'b1; // [R8]
      else if (wr && paddr == `REG_STATUS && pwdata[`STS_ERR_SHORT])
        err_short_q <= 1'b0;
      if (wr && !attr_write_ok && (paddr == `REG_EXPOSURE ||
          paddr == `REG_DARK || paddr == `REG_ATTRIBUTE ||
          paddr == `REG_IMAGE))
        err_refused_q <= 1'b1;
      else if (wr && !order_write_ok && (paddr == `REG_ORDER_ENTRY ||
               paddr == `REG_ORDER_LENGTH))
        err_refused_q <= 1'b1; // [R11]
      else if (wr && paddr == `REG_STATUS && pwdata[`STS_ERR_REFUSED])
        err_refused_q <= 1'b0;
    end
  end

  // Slot attribute and image memory, written by uploads only
  always_ff @(posedge clock)
  begin
    if (wr && attr_write_ok)
    begin
      case (paddr)
        `REG_EXPOSURE:
          if (pwdata[23:0] >= MIN_US)
            attr_q[slot_sel_q].exposure_us <= pwdata[23:0]; // [R8]
        `REG_DARK: attr_q[slot_sel_q].dark_us <= pwdata[23:0];
        `REG_ATTRIBUTE:
        begin
          attr_q[slot_sel_q].depth <=
            pwdata[`ATT_DEPTH_HI:`ATT_DEPTH_LO];
          attr_q[slot_sel_q].color <=
            pwdata[`ATT_COLOR_HI:`ATT_COLOR_LO];
          attr_q[slot_sel_q].trigger <= pwdata[`ATT_TRIGGER];
        end
        `REG_IMAGE: image_q[slot_sel_q] <= pwdata; // [R2] [R10]
        default: ;
      endcase
    end
  end

  // Reorder table; only slot indices are stored here
  always_ff @(posedge clock)
  begin
    if (wr && order_write_ok && paddr == `REG_ORDER_ENTRY)
      order_q[order_sel_q] <= pwdata[SLOT_W-1:0]; // [R1] [R4] [R10]
  end

  // Microsecond tick, held at zero while idle or paused
  // Restarted per pattern so exposures start on a whole microsecond
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      tick_q <= 7'h00;
    else if (idle || paused_q || us_tick ||
             state_q == pattern_order_pkg::st_fetch ||
             state_q == pattern_order_pkg::st_wait_trigger)
      tick_q <= 7'h00;
    else
      tick_q <= tick_q + 7'h01;
  end

  // Pause flag: start resumes from the held position
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      paused_q <= 1'b0;
    else if (cmd_stop || cmd_start)
      paused_q <= 1'b0; // [R15]
    else if (cmd_pause && !idle)
      paused_q <= 1'b1;
  end

  // Display sequencer
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= pattern_order_pkg::st_idle;
      pos_q <= '0;
      slot_q <= '0;
      us_q <= 24'h00_0000;
      acc_q <= 24'h00_0000;
      display_q <= '0;
    end
    else if (cmd_stop)
    begin
      // Stop always rewinds to the first row
      state_q <= pattern_order_pkg::st_idle;
      pos_q <= '0; // [R15]
      display_q.blank <= 1'b1;
      display_q.waiting <= 1'b0;
    end
    else if (!paused_q)
    begin
      case (state_q)
        pattern_order_pkg::st_idle:
          if (cmd_start && order_len_q != '0)
          begin
            pos_q <= '0; // [R15]
            state_q <= pattern_order_pkg::st_fetch;
          end
        pattern_order_pkg::st_fetch:
        begin
          // Attributes come from the named slot, not the row
          slot_q <= fetch_slot; // [R3]
          us_q <= 24'h00_0000;
          acc_q <= 24'h00_0000;
          if (fetch_attr.trigger)
          begin
            // Display left as is: black tail or held last plane
            state_q <= pattern_order_pkg::st_wait_trigger; // [R5] [R9]
            display_q.waiting <= 1'b1;
          end
          else
            state_q <= pattern_order_pkg::st_expose;
        end
        pattern_order_pkg::st_wait_trigger:
          if (trigger_in)
          begin
            display_q.waiting <= 1'b0;
            state_q <= pattern_order_pkg::st_expose; // [R5]
          end
        pattern_order_pkg::st_expose:
        begin
          display_q.pattern_word <= image_q[slot_q]; // [R10]
          display_q.color <= cur_attr.color; // [R3]
          display_q.blank <= 1'b0;
          if (us_q == 24'h00_0000 && acc_q == 24'h00_0000)
            display_q.bit_plane <= 3'h0;
          if (us_tick)
          begin
            us_q <= us_q + 24'h00_0001;
            // Planes share the exposure evenly
            if (acc_q + 24'(cur_attr.depth) >= cur_attr.exposure_us)
            begin
              acc_q <= acc_q + 24'(cur_attr.depth) -
                       cur_attr.exposure_us;
              if (32'(display_q.bit_plane) + 32'd1 <
                  32'(cur_attr.depth))
                display_q.bit_plane <= display_q.bit_plane + 3'h1;
            end
            else
              acc_q <= acc_q + 24'(cur_attr.depth);
            if (us_q + 24'h00_0001 >= cur_attr.exposure_us)
            begin
              us_q <= 24'h00_0000;
              state_q <= pattern_order_pkg::st_dark;
            end
          end
        end
        pattern_order_pkg::st_dark:
        begin
          if (cur_attr.dark_us != 24'h00_0000)
            display_q.blank <= 1'b1;
          if (us_q >= cur_attr.dark_us)
          begin
            us_q <= 24'h00_0000;
            if (tail_black)
            begin
              state_q <= pattern_order_pkg::st_black; // [R6]
              display_q.blank <= 1'b1; // [R5]
            end
            else if (last_row)
            begin
              pos_q <= '0;
              state_q <= repeat_q ? pattern_order_pkg::st_fetch :
                         pattern_order_pkg::st_idle; // [R13]
            end
            else
            begin
              pos_q <= pos_q + 1'b1; // [R1]
              state_q <= pattern_order_pkg::st_fetch;
            end
          end
          else if (us_tick)
            us_q <= us_q + 24'h00_0001;
        end
        pattern_order_pkg::st_black:
          if (us_tick)
          begin
            if (us_q + 24'h00_0001 >= BLACK_US)
            begin
              us_q <= 24'h00_0000; // [R7]
              pos_q <= last_row ? '0 : pos_q + 1'b1;
              state_q <= (!last_row || repeat_q) ?
                         pattern_order_pkg::st_fetch :
                         pattern_order_pkg::st_idle; // [R13]
            end
            else
              us_q <= us_q + 24'h00_0001;
          end
        default: state_q <= pattern_order_pkg::st_idle;
      endcase
    end
  end

endmodule

// file: verilog/pattern_order_pkg.sv
package pattern_order_pkg;

  // Stored attributes of one pattern slot
  typedef struct packed {
    logic [23:0] exposure_us;
    logic [23:0] dark_us;
    logic [3:0] depth;
    logic [2:0] color;
    logic trigger;
  } slot_attr_type;

  // Pattern source modes
  typedef enum logic [1:0] {
    mode_flash,
    mode_upload,
    mode_video,
    mode_spare
  } source_mode_type;

  // Sequencer states
  typedef enum logic [2:0] {
    st_idle,
    st_fetch,
    st_wait_trigger,
    st_expose,
    st_dark,
    st_black
  } seq_state_type;

  // What the display sees
  typedef struct packed {
    logic [31:0] pattern_word;
    logic [2:0] bit_plane;
    logic [2:0] color;
    logic blank;
    logic waiting;
  } display_out_type;

endpackage
